// *** logic/phtp_top.sv ***
`timescale 1ns/1ps
`include "phtp_consts.svh"
module phtp_top #(
    parameter int CW = 20,
    parameter int NOM_FAST_CYC = `PHTP_T_NOM_FAST_US * `PHTP_CLK_MHZ,
    parameter int NOM_SLOW_CYC = `PHTP_T_NOM_SLOW_US * `PHTP_CLK_MHZ,
    parameter int DCHG_0_CYC = `PHTP_T_DCHG_0_US * `PHTP_CLK_MHZ,
    parameter int DCHG_1_CYC = `PHTP_T_DCHG_1_US * `PHTP_CLK_MHZ,
    parameter int DCHG_2_CYC = `PHTP_T_DCHG_2_US * `PHTP_CLK_MHZ,
    parameter int DCHG_3_CYC = `PHTP_T_DCHG_3_US * `PHTP_CLK_MHZ,
    parameter int WIDTH_0_CYC = `PHTP_T_WIDTH_0_US * `PHTP_CLK_MHZ,
    parameter int WIDTH_1_CYC = `PHTP_T_WIDTH_1_US * `PHTP_CLK_MHZ,
    parameter int WIDTH_2_CYC = `PHTP_T_WIDTH_2_US * `PHTP_CLK_MHZ,
    parameter int WIDTH_3_CYC = `PHTP_T_WIDTH_3_US * `PHTP_CLK_MHZ
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Register port, addressed by command code
    input wire logic REG_WR_EN,
    input wire logic REG_RD_EN,
    input wire logic [7:0] REG_CMD,
    input wire logic [15:0] REG_WDATA,
    output logic [15:0] REG_RDATA,
    // Measured currents in mA, same clock
    input wire logic [15:0] INPUT_CURRENT_MA,
    input wire logic [15:0] INPUT_CURRENT_LIMIT_MA,
    input wire logic [15:0] BATTERY_DISCHARGE_CURRENT_MA,
    // Comparator levels from the analog side
    input wire logic CRITICAL_CURRENT_TRIGGER,
    input wire logic SYSVOLT_TRIGGER,
    input wire logic COMPARATOR_TRIGGER,
    input wire logic BATTERY_PRESENCE,
    // Alert to the host processor
    output logic PROCESSOR_OVERHEAT_ALERT_N
);
    logic [15:0] opt_a_r;
    logic [15:0] opt_a_nxt;
    logic [15:0] opt_b_r;
    logic [15:0] opt_b_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic clear_wr;
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic bat_prev_r;
    logic bat_fall;
    logic nom_raw;
    logic dchg_raw;
    logic nom_dg;
    logic dchg_dg;
    logic [16:0] dchg_level;
    logic [CW-1:0] nom_need;
    logic [CW-1:0] dchg_need;
    logic [CW-1:0] width_need;
    logic [6:0] prof;
    logic fn_en;
    logic ext_en;
    logic any_trig;
    phtp_pkg::phtp_state_t state_r;
    phtp_pkg::phtp_state_t state_nxt;
    logic [CW-1:0] pulse_cnt_r;
    logic [CW-1:0] pulse_cnt_nxt;
    logic alert_n_r;
    logic alert_n_nxt;

    // Command decode, shared by write and read paths
    function automatic phtp_pkg::phtp_sel_t reg_sel(input logic [7:0] cmd);
        if (cmd == `PHTP_CMD_OPT_A) begin
            return phtp_pkg::PHTP_SEL_A;
        end else if (cmd == `PHTP_CMD_OPT_B) begin
            return phtp_pkg::PHTP_SEL_B;
        end else begin
            return phtp_pkg::PHTP_SEL_NONE;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers
    ////////////////////////////////////////////////////////////////////////

    // A written 0 in the clear bit acts once; the bit itself rests at 1
    assign clear_wr = REG_WR_EN && (reg_sel(REG_CMD) == phtp_pkg::PHTP_SEL_A)
        && !REG_WDATA[`PHTP_A_CLEAR_BIT];

    always_comb begin
        opt_a_nxt = opt_a_r;
        opt_b_nxt = opt_b_r;
        rdata_nxt = rdata_r;
        if (REG_WR_EN && reg_sel(REG_CMD) == phtp_pkg::PHTP_SEL_A) begin
            opt_a_nxt = REG_WDATA;
            opt_a_nxt[`PHTP_A_CLEAR_BIT] = 1'b1;
        end
        if (REG_WR_EN && reg_sel(REG_CMD) == phtp_pkg::PHTP_SEL_B) begin
            opt_b_nxt = REG_WDATA;
        end
        // Unmapped codes read as zero
        if (REG_RD_EN) begin
            unique case (reg_sel(REG_CMD))
                phtp_pkg::PHTP_SEL_A: rdata_nxt = opt_a_r;
                phtp_pkg::PHTP_SEL_B: rdata_nxt = opt_b_r;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            opt_a_r <= `PHTP_OPT_A_RST;
            opt_b_r <= `PHTP_OPT_B_RST;
            rdata_r <= 16'h0000;
        end else begin
            opt_a_r <= opt_a_nxt;
            opt_b_r <= opt_b_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign prof = opt_b_r[`PHTP_B_PROF_MSB:0];
    assign ext_en = opt_a_r[`PHTP_A_EXT_BIT];
    assign fn_en = |prof;

    ////////////////////////////////////////////////////////////////////////
    // Input sampling and trigger sources
    ////////////////////////////////////////////////////////////////////////

    // Pins from the analog side are asynchronous: two flops first
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            bat_prev_r <= 1'b0;
        end else begin
            sync1_r <= {BATTERY_PRESENCE, COMPARATOR_TRIGGER,
                SYSVOLT_TRIGGER, CRITICAL_CURRENT_TRIGGER};
            sync2_r <= sync1_r;
            bat_prev_r <= sync2_r[3];
        end
    end

    assign bat_fall = bat_prev_r && !sync2_r[3];

    // Scaled compare avoids rounding the 110 % level
    assign nom_raw = (20'(INPUT_CURRENT_MA) * `PHTP_NOM_SCALE_CUR) >
        (20'(INPUT_CURRENT_LIMIT_MA) * `PHTP_NOM_SCALE_LIM);
    assign dchg_level = 17'({opt_b_r[`PHTP_B_THR_MSB:`PHTP_B_THR_LSB],
        `PHTP_DCHG_STEP_ZEROS}) + `PHTP_DCHG_OFFSET_MA;
    assign dchg_raw = 17'(BATTERY_DISCHARGE_CURRENT_MA) > dchg_level;

    // Deglitch and pulse width selections
    always_comb begin
        nom_need = opt_a_r[`PHTP_A_NOMDEG_BIT] ? CW'(NOM_SLOW_CYC)
            : CW'(NOM_FAST_CYC);
        unique case (opt_b_r[`PHTP_B_DEG_MSB:`PHTP_B_DEG_LSB])
            2'b00: dchg_need = CW'(DCHG_0_CYC);
            2'b01: dchg_need = CW'(DCHG_1_CYC);
            2'b10: dchg_need = CW'(DCHG_2_CYC);
            2'b11: dchg_need = CW'(DCHG_3_CYC);
        endcase
        unique case (opt_a_r[`PHTP_A_WIDTH_MSB:`PHTP_A_WIDTH_LSB])
            2'b00: width_need = CW'(WIDTH_0_CYC);
            2'b01: width_need = CW'(WIDTH_1_CYC);
            2'b10: width_need = CW'(WIDTH_2_CYC);
            2'b11: width_need = CW'(WIDTH_3_CYC);
        endcase
    end

    phtp_deglitch #(.CW(CW)) u_nom_dg (
        .clk(MCLK),
        .rst_n(RST_N),
        .need_cyc(nom_need),
        .level_in(nom_raw),
        .level_out(nom_dg)
    );

    phtp_deglitch #(.CW(CW)) u_dchg_dg (
        .clk(MCLK),
        .rst_n(RST_N),
        .need_cyc(dchg_need),
        .level_in(dchg_raw),
        .level_out(dchg_dg)
    );

    // Enabled sources ORed; critical, sysvolt, comparator arrive synchronized only, not deglitched
    assign any_trig = fn_en && (
        (prof[`PHTP_B_COMP_BIT] && sync2_r[2]) ||
        (prof[`PHTP_B_CRIT_BIT] && sync2_r[0]) ||
        (prof[`PHTP_B_NOM_BIT] && nom_dg) ||
        (prof[`PHTP_B_DCHG_BIT] && dchg_dg) ||
        (prof[`PHTP_B_SYSV_BIT] && sync2_r[1]) ||
        (prof[`PHTP_B_BATP_BIT] && bat_fall));

    ////////////////////////////////////////////////////////////////////////
    // Alert sequencer
    ////////////////////////////////////////////////////////////////////////

    // Minimum width applies without extension; with extension on, a clear write wins over
    // a trigger in the same cycle; a source still active is seen one cycle later, a battery removal edge is lost
    always_comb begin
        state_nxt = state_r;
        pulse_cnt_nxt = pulse_cnt_r;
        unique case (state_r)
            phtp_pkg::PHTP_IDLE: begin
                if (any_trig) begin
                    state_nxt = phtp_pkg::PHTP_PULSE;
                    pulse_cnt_nxt = width_need;
                end
            end
            phtp_pkg::PHTP_PULSE: begin
                if (ext_en) begin
                    state_nxt = phtp_pkg::PHTP_HOLD;
                end else if (any_trig) begin
                    pulse_cnt_nxt = width_need;
                end else if (pulse_cnt_r <= CW'(1)) begin
                    state_nxt = phtp_pkg::PHTP_IDLE;
                end else begin
                    pulse_cnt_nxt = pulse_cnt_r - CW'(1);
                end
            end
            phtp_pkg::PHTP_HOLD: begin
                if (!ext_en) begin
                    state_nxt = phtp_pkg::PHTP_IDLE;
                end
            end
        endcase
        if (!fn_en || (ext_en && clear_wr)) begin
            state_nxt = phtp_pkg::PHTP_IDLE;
        end
        alert_n_nxt = (state_nxt == phtp_pkg::PHTP_IDLE);
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_r <= phtp_pkg::PHTP_IDLE;
            pulse_cnt_r <= '0;
            alert_n_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
            alert_n_r <= alert_n_nxt;
        end
    end

    assign PROCESSOR_OVERHEAT_ALERT_N = alert_n_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    ////////////////////////////////////////////////////////////////////////

    // Run lengths of raw trigger levels, watched by the deglitch checks
    logic [CW-1:0] nom_run_r;
    logic [CW-1:0] dchg_run_r;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            nom_run_r <= '0;
            dchg_run_r <= '0;
        end else begin
            nom_run_r <= nom_raw ? nom_run_r + CW'(1) : '0;
            dchg_run_r <= dchg_raw ? dchg_run_r + CW'(1) : '0;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    AST_CLEAR_RELEASE: assert property (
        ext_en && clear_wr |=> PROCESSOR_OVERHEAT_ALERT_N)
        else $error("clear write did not release the alert");
    AST_NOM_LEVEL: assert property (
        $rose(nom_dg) |-> $past(nom_raw))
        else $error("nominal trigger rose without excess current");
    AST_NOM_DEG: assert property (
        $rose(nom_dg) |-> nom_run_r == nom_need)
        else $error("nominal deglitch time wrong");
    AST_DCHG_LEVEL: assert property (
        $rose(dchg_dg) |-> $past(BATTERY_DISCHARGE_CURRENT_MA) >
        $past(dchg_level))
        else $error("discharge trigger rose below threshold");
    AST_DCHG_DEG: assert property (
        $rose(dchg_dg) |-> dchg_run_r == dchg_need)
        else $error("discharge deglitch time wrong");
    AST_FN_OFF: assert property (
        !fn_en |=> PROCESSOR_OVERHEAT_ALERT_N)
        else $error("alert active with all profiles off");
    AST_BAT_ONESHOT: assert property (
        bat_fall && prof[`PHTP_B_BATP_BIT] |=> !PROCESSOR_OVERHEAT_ALERT_N)
        else $error("battery removal gave no pulse");
    AST_HOLD_LOW: assert property (
        state_r == phtp_pkg::PHTP_HOLD && ext_en && !clear_wr && fn_en
        |-> !PROCESSOR_OVERHEAT_ALERT_N [*2])
        else $error("extended alert released without clear");
    AST_OR_SOURCES: assert property (
        state_r == phtp_pkg::PHTP_IDLE && !any_trig
        |=> PROCESSOR_OVERHEAT_ALERT_N)
        else $error("alert without an enabled source");
    AST_MIN_WIDTH: assert property (
        $fell(PROCESSOR_OVERHEAT_ALERT_N) && fn_en && !ext_en
        && width_need > CW'(8)
        |-> !PROCESSOR_OVERHEAT_ALERT_N [*8] or
        ##[1:8] (!fn_en || ext_en))
        else $error("alert pulse shorter than minimum width");
endmodule

// *** logic/phtp_consts.svh ***
`ifndef PHTP_CONSTS_SVH
`define PHTP_CONSTS_SVH

// Command codes of the two option registers
`define PHTP_CMD_OPT_A 8'h33
`define PHTP_CMD_OPT_B 8'h34

// Power-on values
`define PHTP_OPT_A_RST 16'h4a54
`define PHTP_OPT_B_RST 16'h8120

// Option A field positions
`define PHTP_A_EXT_BIT 5
`define PHTP_A_WIDTH_MSB 4
`define PHTP_A_WIDTH_LSB 3
`define PHTP_A_CLEAR_BIT 2
`define PHTP_A_NOMDEG_BIT 1

// Option B field positions
`define PHTP_B_THR_MSB 15
`define PHTP_B_THR_LSB 10
`define PHTP_B_DEG_MSB 9
`define PHTP_B_DEG_LSB 8
`define PHTP_B_PROF_MSB 6
`define PHTP_B_COMP_BIT 6
`define PHTP_B_CRIT_BIT 5
`define PHTP_B_NOM_BIT 4
`define PHTP_B_DCHG_BIT 3
`define PHTP_B_SYSV_BIT 2
`define PHTP_B_BATP_BIT 1

// Current arithmetic: 110 % margin, 512 mA step, 128 mA offset
`define PHTP_NOM_SCALE_CUR 20'h0_000a
`define PHTP_NOM_SCALE_LIM 20'h0_000b
`define PHTP_DCHG_STEP_ZEROS 9'h000
`define PHTP_DCHG_OFFSET_MA 17'h0_0080

// Clock rate and times in microseconds
`define PHTP_CLK_MHZ 10
`define PHTP_T_NOM_FAST_US 1000
`define PHTP_T_NOM_SLOW_US 50000
`define PHTP_T_DCHG_0_US 1600
`define PHTP_T_DCHG_1_US 100
`define PHTP_T_DCHG_2_US 6000
`define PHTP_T_DCHG_3_US 12000
`define PHTP_T_WIDTH_0_US 100
`define PHTP_T_WIDTH_1_US 1000
`define PHTP_T_WIDTH_2_US 10000
`define PHTP_T_WIDTH_3_US 5000

`endif

// *** logic/phtp_pkg.sv ***
package phtp_pkg;
    // Alert sequencer, Gray coded along idle -> pulse -> hold
    typedef enum logic [1:0] {
        PHTP_IDLE = 2'b00,
        PHTP_PULSE = 2'b01,
        PHTP_HOLD = 2'b11
    } phtp_state_t;
    // Register selected by a command code
    typedef enum logic [1:0] {
        PHTP_SEL_NONE = 2'b00,
        PHTP_SEL_A = 2'b01,
        PHTP_SEL_B = 2'b10
    } phtp_sel_t;
endpackage

// *** logic/phtp_deglitch.sv ***
`timescale 1ns/1ps
// Level filter: output rises after need_cyc consecutive high samples
module phtp_deglitch #(
    parameter int CW = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filter
    input wire logic [CW-1:0] need_cyc,
    input wire logic level_in,
    output logic level_out
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic out_r;
    logic out_nxt;

    // Any low sample restarts the wait, so glitches never pass
    always_comb begin
        cnt_nxt = '0;
        out_nxt = 1'b0;
        if (level_in) begin
            if (cnt_r + 1'b1 >= need_cyc) begin
                cnt_nxt = cnt_r;
                out_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign level_out = out_r;
endmodule

// *** tb/phtp_host_model.sv ***
`timescale 1ns/1ps
// Host side of the register port: one-cycle command strobes
module phtp_host_model (
    // Clock
    input wire logic clk,
    // Register port toward the device
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] cmd,
    output logic [15:0] wdata,
    input wire logic [15:0] rdata
);
    // Idle bus from time zero
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        cmd = 8'h00;
        wdata = 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////
    // Write: strobe and data held over exactly one sampling edge
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        cmd <= c;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    // Read: data is registered at the sampling edge, so look just after
    task automatic rd(input logic [7:0] c, output logic [15:0] d);
        @(posedge clk);
        rd_en <= 1'b1;
        cmd <= c;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    // With the extension bit and a profile left on, release of an extended alert needs this write of 0 to the clear bit
    task automatic clear_alert(input logic [15:0] opt_a);
        wr(8'h33, opt_a & 16'hfffb);
    endtask
endmodule

// *** tb/test_processor_hot_trigger_profile.sv ***
`timescale 1ns/1ps
module test_processor_hot_trigger_profile;
    // Short counts keep the run brief; expectations use the same values
    localparam int W2 = 40;
    localparam int W1 = 30;
    localparam int W3 = 35;
    localparam int W0 = 20;
    localparam int NF = 10;
    localparam int NS = 40;
    localparam int LIMIT = 20000;
    localparam int DG[4] = '{16, 8, 24, 32};
    logic MCLK;
    logic RST_N;
    logic wr_en;
    logic rd_en;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] in_ma;
    logic [15:0] lim_ma;
    logic [15:0] dchg_ma;
    logic [2:0] pins;
    logic batp;
    logic alert_n;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////
    // Device and host
    phtp_top #(.NOM_FAST_CYC(NF), .NOM_SLOW_CYC(NS), .DCHG_0_CYC(DG[0]),
        .DCHG_1_CYC(DG[1]), .DCHG_2_CYC(DG[2]), .DCHG_3_CYC(DG[3]),
        .WIDTH_0_CYC(W0), .WIDTH_1_CYC(W1), .WIDTH_2_CYC(W2),
        .WIDTH_3_CYC(W3)) i_dut (
        .MCLK(MCLK), .RST_N(RST_N), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
        .REG_CMD(cmd), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .INPUT_CURRENT_MA(in_ma), .INPUT_CURRENT_LIMIT_MA(lim_ma),
        .BATTERY_DISCHARGE_CURRENT_MA(dchg_ma),
        .CRITICAL_CURRENT_TRIGGER(pins[1]), .SYSVOLT_TRIGGER(pins[2]),
        .COMPARATOR_TRIGGER(pins[0]), .BATTERY_PRESENCE(batp),
        .PROCESSOR_OVERHEAT_ALERT_N(alert_n));
    phtp_host_model i_host (.clk(MCLK), .wr_en(wr_en), .rd_en(rd_en),
        .cmd(cmd), .wdata(wdata), .rdata(rdata));

    ////////////////////////////////////////////////////////////////////////
    // Checking helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_in(input int n, input int lo, input int hi);
        n_checks++;
        if (n < lo || n > hi) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
        end
    endtask

    // Bounded wait for the alert level; n counts edges waited
    task automatic wait_lvl(input logic lvl, input int lim, output int n);
        n = 0;
        // Step off the edge so a freshly launched level is settled
        #1;
        while (alert_n !== lvl && n < lim) begin
            @(posedge MCLK);
            #1;
            n++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        logic [15:0] d;
        i_host.rd(8'h33, d);
        chk(d, 16'h4a54);
        i_host.rd(8'h34, d);
        chk(d, 16'h8120);
        i_host.rd(8'h35, d);
        chk(d, 16'h0000);
        chk(alert_n, 1'b1);
    endtask

    // Each pin source alone; a foreign pin must not fire it
    task automatic t_sources();
        int n;
        int bitpos[3] = '{6, 5, 2};
        for (int k = 0; k < 3; k++) begin
            i_host.wr(8'h34, 16'h0001 << bitpos[k]);
            @(posedge MCLK);
            pins[(k + 1) % 3] <= 1'b1;
            repeat (10) @(posedge MCLK);
            pins[(k + 1) % 3] <= 1'b0;
            #1;
            chk(alert_n, 1'b1);
            repeat (4) @(posedge MCLK);
            pins[k] <= 1'b1;
            wait_lvl(1'b0, 8, n);
            chk_in(n, 1, 6);
            @(posedge MCLK);
            pins[k] <= 1'b0;
            wait_lvl(1'b1, W2 + 10, n);
            chk_in(n, W2 - 1, W2 + 4);
        end
        // Every profile off: the function is dead
        i_host.wr(8'h34, 16'h0000);
        @(posedge MCLK);
        pins <= 3'b111;
        repeat (10) @(posedge MCLK);
        pins <= 3'b000;
        #1;
        chk(alert_n, 1'b1);
    endtask

    // Battery removal gives one pulse even though it stays removed
    task automatic t_battery();
        int n;
        i_host.wr(8'h34, 16'h0002);
        @(posedge MCLK);
        batp <= 1'b0;
        wait_lvl(1'b0, 8, n);
        chk_in(n, 1, 6);
        wait_lvl(1'b1, W2 + 10, n);
        chk_in(n, W2 - 4, W2 + 4);
        repeat (W2 + 10) @(posedge MCLK);
        #1;
        chk(alert_n, 1'b1);
        @(posedge MCLK);
        batp <= 1'b1;
    endtask

    task automatic t_ext_clear();
        int n;
        logic [15:0] d;
        i_host.wr(8'h34, 16'h0020);
        i_host.wr(8'h33, 16'h4a74);
        @(posedge MCLK);
        pins[1] <= 1'b1;
        wait_lvl(1'b0, 8, n);
        @(posedge MCLK);
        pins[1] <= 1'b0;
        repeat (W2 + 20) @(posedge MCLK);
        #1;
        chk(alert_n, 1'b0);
        i_host.rd(8'h33, d);
        chk(d, 16'h4a74);
        i_host.clear_alert(16'h4a74);
        wait_lvl(1'b1, 3, n);
        chk_in(n, 0, 2);
        i_host.wr(8'h33, 16'h4a44);
    endtask

    // Code 33 threshold: 33 * 512 + 128 = 17024 mA, all four filters
    task automatic t_discharge();
        int n;
        logic [1:0] g;
        // Width code 11 here, so its 5 ms count is also exercised
        i_host.wr(8'h33, 16'h4a5c);
        for (int k = 0; k < 4; k++) begin
            g = k[1:0];
            i_host.wr(8'h34, {6'h21, g, 8'h08});
            @(posedge MCLK);
            dchg_ma <= 16'h4280;
            repeat (DG[k] + 8) @(posedge MCLK);
            #1;
            chk(alert_n, 1'b1);
            @(posedge MCLK);
            dchg_ma <= 16'h4281;
            wait_lvl(1'b0, DG[k] + 8, n);
            chk_in(n, DG[k], DG[k] + 4);
            @(posedge MCLK);
            dchg_ma <= 16'h0000;
            wait_lvl(1'b1, W3 + 10, n);
            chk_in(n, W3 - 1, W3 + 4);
            chk(alert_n, 1'b1);
        end
    endtask

    // Limit 1000 mA: 1100 mA is not above 110 %, 1101 mA is
    task automatic t_nominal();
        int n;
        int nd;
        int wd;
        i_host.wr(8'h34, 16'h0010);
        // Slow filter paired with width code 01
        for (int s = 0; s < 2; s++) begin
            nd = (s == 0) ? NF : NS;
            wd = (s == 0) ? W0 : W1;
            i_host.wr(8'h33, (s == 0) ? 16'h4a44 : 16'h4a4e);
            @(posedge MCLK);
            in_ma <= 16'h044c;
            repeat (nd + 8) @(posedge MCLK);
            #1;
            chk(alert_n, 1'b1);
            @(posedge MCLK);
            in_ma <= 16'h044d;
            wait_lvl(1'b0, nd + 8, n);
            chk_in(n, nd, nd + 4);
            @(posedge MCLK);
            in_ma <= 16'h0000;
            wait_lvl(1'b1, wd + 10, n);
            chk_in(n, wd - 1, wd + 4);
            chk(alert_n, 1'b1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock, hang guard and main sequence
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end

    always @(posedge MCLK) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        RST_N = 1'b0;
        in_ma = 16'h0000;
        lim_ma = 16'h03e8;
        dchg_ma = 16'h0000;
        pins = 3'b000;
        batp = 1'b1;
        repeat (4) @(posedge MCLK);
        RST_N <= 1'b1;
        t_reset();
        t_sources();
        t_battery();
        t_ext_clear();
        t_discharge();
        t_nominal();
        final_report();
    end
endmodule
